// [rtl/dpdc_device_control.v]
// device control register of one downstream port, with error message gating
`timescale 1ns/100ps
`include "dpdc_defs.vh"

// Function
// RQ1 - bit 15 reserved, reads zero
// RQ2 - read request size: writable 3-bit code
// RQ3 - read request size resets to 512 bytes
// RQ4 - read fetch uses request size and cache line
// RQ5 - no snoop enable reads zero
// RQ6 - aux power enable reads zero
// RQ7 - phantom function enable reads zero
// RQ8 - extended tag enable reads zero
// RQ9 - payload size: writable 3-bit code
// RQ10 - payload size resets to 128 bytes
// RQ11 - relaxed ordering enable reads zero
// RQ12 - unsupported request sends nonfatal when enabled
// RQ13 - system error sends fatal when enabled
// RQ14 - system error sends nonfatal when enabled
// RQ15 - system error sends correctable when enabled
// RQ16 - register at 98h, resets to 2000h
// RQ17 - errors logged whatever the enables say
// RQ18 - only size fields and enables store writes
module dpdc_device_control #(
  parameter SIZE_W = 13,
  parameter CLS_W = 8
) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire i_cfg_wr,
  input wire i_cfg_rd,
  input wire [11:0] i_cfg_addr,
  input wire [1:0] i_cfg_be,
  input wire [15:0] i_cfg_wdata,
  input wire [CLS_W-1:0] i_cache_line_size,
  input wire i_ur_event,
  input wire i_fatal_event,
  input wire i_nonfatal_event,
  input wire i_corr_event,
  input wire [3:0] i_status_clr,
  output reg [15:0] o_cfg_rdata,
  output reg o_cfg_rd_valid,
  output reg o_cfg_hit,
  output reg [2:0] o_max_read_req_size,
  output reg [2:0] o_max_payload_size,
  output reg [SIZE_W-1:0] o_read_fetch_bytes,
  output reg [SIZE_W-1:0] o_max_payload_bytes,
  output reg o_msg_err_fatal,
  output reg o_msg_err_nonfatal,
  output reg o_msg_err_corr,
  output reg [3:0] o_err_detected
);

  // ********************************************************
  // helpers
  // ********************************************************

  // reserved codes fall back to the smallest size so a bad program
  // can never let a transfer exceed what the far end accepts
  function [SIZE_W-1:0] size_bytes;
    input [2:0] code;
    begin
      if (code > `DPDC_SIZE_MAX_CODE) begin
        size_bytes = `DPDC_SIZE_MIN_BYTES;
      end else begin
        size_bytes = `DPDC_SIZE_MIN_BYTES << code;
      end
    end
  endfunction

  function [15:0] merge_lanes;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0] be;
    reg [15:0] lane_mask;
    begin
      lane_mask = {{8{be[1]}}, {8{be[0]}}} & `DPDC_CTRL_WR_MASK;
      merge_lanes = (old_val & ~lane_mask) | (new_val & lane_mask);
    end
  endfunction

  // a message only leaves when its reporting enable is set
  function gate_msg;
    input evt;
    input en;
    begin
      gate_msg = evt & en;
    end
  endfunction

  // sticky flag: a new event beats a clear in the same cycle, so no
  // error that lands on the clear is ever lost
  function sticky_flag;
    input old_flag;
    input clr;
    input evt;
    begin
      sticky_flag = (old_flag & ~clr) | evt;
    end
  endfunction

  // ********************************************************
  // register storage
  // ********************************************************

  reg [2:0] max_read_req_size_q;
  reg [2:0] max_read_req_size_d;
  reg [2:0] mps_q;
  reg [2:0] mps_d;
  reg [3:0] rpt_en_q;
  reg [3:0] rpt_en_d;
  reg [3:0] err_q;
  reg [3:0] err_d;
  reg [15:0] ctrl_view;
  reg [15:0] ctrl_merged;
  reg [SIZE_W-1:0] fetch_d;
  reg [SIZE_W+2-1:0] cls_bytes;
  reg nonfatal_msg_d;
  wire addr_hit;
  wire wr_hit;

  // the full byte address is compared; an access two bytes higher
  // belongs to the status register next door and must not hit
  assign addr_hit = (i_cfg_addr == `DPDC_CTRL_OFFSET); // RQ16
  assign wr_hit = i_cfg_wr & addr_hit;

  // read view: read-only enables and the reserved top bit are tied low
  // so software probing for optional features finds them absent
  always @* begin
    ctrl_view = 16'h0000;
    ctrl_view[`DPDC_RSVD_BIT] = 1'b0; // RQ1
    ctrl_view[`DPDC_MAX_READ_REQ_SIZE_MSB:`DPDC_MAX_READ_REQ_SIZE_LSB] = max_read_req_size_q; // RQ2
    ctrl_view[`DPDC_NO_SNOOP_BIT] = 1'b0; // RQ5
    ctrl_view[`DPDC_AUX_PM_BIT] = 1'b0; // RQ6
    ctrl_view[`DPDC_PHANTOM_BIT] = 1'b0; // RQ7
    ctrl_view[`DPDC_EXT_TAG_BIT] = 1'b0; // RQ8
    ctrl_view[`DPDC_MPS_MSB:`DPDC_MPS_LSB] = mps_q; // RQ9
    ctrl_view[`DPDC_RELAXED_BIT] = 1'b0; // RQ11
    ctrl_view[`DPDC_UR_EN_BIT:`DPDC_CORR_EN_BIT] = rpt_en_q;
  end

  // write path: lanes merged through the writable mask only
  always @* begin
    ctrl_merged = merge_lanes(ctrl_view, i_cfg_wdata, i_cfg_be); // RQ18
    max_read_req_size_d = max_read_req_size_q;
    mps_d = mps_q;
    rpt_en_d = rpt_en_q;
    if (wr_hit) begin
      max_read_req_size_d = ctrl_merged[`DPDC_MAX_READ_REQ_SIZE_MSB:`DPDC_MAX_READ_REQ_SIZE_LSB]; // RQ2
      mps_d = ctrl_merged[`DPDC_MPS_MSB:`DPDC_MPS_LSB]; // RQ9
      rpt_en_d = ctrl_merged[`DPDC_UR_EN_BIT:`DPDC_CORR_EN_BIT]; // RQ18
    end
  end

  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      max_read_req_size_q <= `DPDC_MAX_READ_REQ_SIZE_RESET; // RQ3
    end else begin
      max_read_req_size_q <= max_read_req_size_d;
    end
  end

  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      mps_q <= `DPDC_MPS_RESET; // RQ10
    end else begin
      mps_q <= mps_d;
    end
  end

  // enables come up clear so nothing is reported before software asks
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rpt_en_q <= `DPDC_RPT_EN_RESET; // RQ16
    end else begin
      rpt_en_q <= rpt_en_d;
    end
  end

  // ********************************************************
  // configuration read answer
  // ********************************************************

  // one cycle of latency; every read is answered so the requester never
  // waits on an address this block does not own
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cfg_rd_valid <= 1'b0;
      o_cfg_hit <= 1'b0;
    end else begin
      o_cfg_rd_valid <= i_cfg_rd;
      o_cfg_hit <= (i_cfg_rd | i_cfg_wr) & addr_hit; // RQ16
    end
  end

  // an unmapped read answers zero; data drops back to zero after one
  // cycle so a stale word cannot be mistaken for a later answer
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_cfg_rdata <= 16'h0000;
    end else if (i_cfg_rd & addr_hit) begin
      o_cfg_rdata <= ctrl_view; // RQ1
    end else begin
      o_cfg_rdata <= 16'h0000;
    end
  end

  // ********************************************************
  // size limits for the transaction logic
  // ********************************************************

  // cache line size counts dwords; zero means unprogrammed, so the
  // request size alone limits the fetch
  always @* begin
    cls_bytes = {{(SIZE_W-CLS_W){1'b0}}, i_cache_line_size, 2'b00};
    fetch_d = size_bytes(max_read_req_size_q);
    if ((i_cache_line_size != {CLS_W{1'b0}}) && (cls_bytes < {2'b00, fetch_d})) begin
      fetch_d = cls_bytes[SIZE_W-1:0]; // RQ4
    end
  end

  // the codes are copied out a cycle late; consumers that need the
  // field and the byte limit in step should use both outputs together
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_max_read_req_size <= `DPDC_MAX_READ_REQ_SIZE_RESET;
      o_max_payload_size <= `DPDC_MPS_RESET;
    end else begin
      o_max_read_req_size <= max_read_req_size_q; // RQ2
      o_max_payload_size <= mps_q; // RQ9
    end
  end

  // byte limits read zero in reset so no transfer can start before the
  // first clock after release
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_read_fetch_bytes <= {SIZE_W{1'b0}};
      o_max_payload_bytes <= {SIZE_W{1'b0}};
    end else begin
      o_read_fetch_bytes <= fetch_d; // RQ4
      o_max_payload_bytes <= size_bytes(mps_q); // RQ9
    end
  end

  // ********************************************************
  // error messages and detection flags
  // ********************************************************

  // an unsupported request and a nonfatal event in the same cycle
  // share one message; the root complex only needs one notice
  always @* begin
    nonfatal_msg_d = gate_msg(i_nonfatal_event, rpt_en_q[`DPDC_NONFATAL_EN_BIT]) | // RQ14
                     gate_msg(i_ur_event, rpt_en_q[`DPDC_UR_EN_BIT]); // RQ12
  end

  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_msg_err_fatal <= 1'b0;
    end else begin
      o_msg_err_fatal <= gate_msg(i_fatal_event, rpt_en_q[`DPDC_FATAL_EN_BIT]); // RQ13
    end
  end

  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_msg_err_nonfatal <= 1'b0;
    end else begin
      o_msg_err_nonfatal <= nonfatal_msg_d; // RQ12
    end
  end

  // correctable reports are the noisiest, so they have their own enable
  // and never ride on the nonfatal path
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_msg_err_corr <= 1'b0;
    end else begin
      o_msg_err_corr <= gate_msg(i_corr_event, rpt_en_q[`DPDC_CORR_EN_BIT]); // RQ15
    end
  end

  // flags are sticky and ignore the enables; a new event beats a clear
  always @* begin
    err_d = err_q;
    err_d[`DPDC_STS_CORR] = sticky_flag(err_q[`DPDC_STS_CORR],
      i_status_clr[`DPDC_STS_CORR], i_corr_event); // RQ17
    err_d[`DPDC_STS_NONFATAL] = sticky_flag(err_q[`DPDC_STS_NONFATAL],
      i_status_clr[`DPDC_STS_NONFATAL], i_nonfatal_event); // RQ17
    err_d[`DPDC_STS_FATAL] = sticky_flag(err_q[`DPDC_STS_FATAL],
      i_status_clr[`DPDC_STS_FATAL], i_fatal_event); // RQ17
    err_d[`DPDC_STS_UR] = sticky_flag(err_q[`DPDC_STS_UR],
      i_status_clr[`DPDC_STS_UR], i_ur_event); // RQ17
  end

  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      err_q <= 4'h0;
      o_err_detected <= 4'h0;
    end else begin
      err_q <= err_d;
      o_err_detected <= err_d;
    end
  end

endmodule // dpdc_device_control

// [rtl/dpdc_defs.vh]
// constants for the downstream port device control register
`ifndef DPDC_DEFS_VH
`define DPDC_DEFS_VH

// ********************************************************
// register placement and reset
// ********************************************************
`define DPDC_CTRL_OFFSET 12'h098
`define DPDC_CTRL_RESET 16'h2000
`define DPDC_CTRL_WR_MASK 16'h70ef

// ********************************************************
// field positions
// ********************************************************
`define DPDC_RSVD_BIT 15
`define DPDC_MAX_READ_REQ_SIZE_MSB 14
`define DPDC_MAX_READ_REQ_SIZE_LSB 12
`define DPDC_NO_SNOOP_BIT 11
`define DPDC_AUX_PM_BIT 10
`define DPDC_PHANTOM_BIT 9
`define DPDC_EXT_TAG_BIT 8
`define DPDC_MPS_MSB 7
`define DPDC_MPS_LSB 5
`define DPDC_RELAXED_BIT 4
`define DPDC_UR_EN_BIT 3
`define DPDC_FATAL_EN_BIT 2
`define DPDC_NONFATAL_EN_BIT 1
`define DPDC_CORR_EN_BIT 0

// ********************************************************
// field reset values and size encodings
// ********************************************************
`define DPDC_MAX_READ_REQ_SIZE_RESET 3'h2
`define DPDC_MPS_RESET 3'h0
`define DPDC_RPT_EN_RESET 4'h0
`define DPDC_SIZE_MAX_CODE 3'h5
`define DPDC_SIZE_MIN_BYTES 13'h0080

// ********************************************************
// status flag positions
// ********************************************************
`define DPDC_STS_CORR 0
`define DPDC_STS_NONFATAL 1
`define DPDC_STS_FATAL 2
`define DPDC_STS_UR 3

`endif

// [verification/dpdc_props.sv]
// assertions on the device control register ports
`timescale 1ns/100ps
module dpdc_props #(
  parameter SIZE_W = 13
) (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire i_cfg_wr,
  input wire i_cfg_rd,
  input wire [11:0] i_cfg_addr,
  input wire i_ur_event,
  input wire i_fatal_event,
  input wire i_nonfatal_event,
  input wire i_corr_event,
  input wire [15:0] o_cfg_rdata,
  input wire o_cfg_rd_valid,
  input wire o_cfg_hit,
  input wire [2:0] o_max_payload_size,
  input wire [SIZE_W-1:0] o_max_payload_bytes,
  input wire o_msg_err_fatal,
  input wire o_msg_err_nonfatal,
  input wire o_msg_err_corr,
  input wire [3:0] o_err_detected
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_sys_rst);
  sequence hit_s;
    (i_cfg_wr || i_cfg_rd) && i_cfg_addr == 12'h098;
  endsequence
  rd_answer_a: assert property (i_cfg_rd |=> o_cfg_rd_valid) else $error("no read answer");
  addr_hit_a: assert property (hit_s |=> o_cfg_hit) else $error("hit missing");
  idle_hit_a: assert property (!i_cfg_wr && !i_cfg_rd |=> !o_cfg_hit) else $error("stray hit");
  ro_zero_a: assert property (o_cfg_rd_valid |-> (o_cfg_rdata & 16'h8f10) == 16'h0)
    else $error("read only bit set");
  fatal_msg_a: assert property (o_msg_err_fatal |-> $past(i_fatal_event))
    else $error("fatal msg without event");
  nonfatal_msg_a: assert property (o_msg_err_nonfatal |-> $past(i_nonfatal_event || i_ur_event))
    else $error("nonfatal msg without event");
  corr_msg_a: assert property (o_msg_err_corr |-> $past(i_corr_event))
    else $error("corr msg without event");
  fatal_log_a: assert property (i_fatal_event |=> o_err_detected[2]) else $error("not logged");
  payload_bytes_a: assert property (!$past(i_sys_rst) |-> o_max_payload_bytes ==
    ((o_max_payload_size > 3'h5) ? 128 : 128 << o_max_payload_size)) else $error("bad payload bytes");
endmodule // dpdc_props

// [verification/dpdc_rc_model.sv]
// root complex stand-in that counts the error messages it receives
`timescale 1ns/100ps
module dpdc_rc_model (
  input wire i_ref_clk,
  input wire i_sys_rst,
  input wire i_fatal,
  input wire i_nonfatal,
  input wire i_corr,
  output reg [7:0] o_n_fatal,
  output reg [7:0] o_n_nonfatal,
  output reg [7:0] o_n_corr
);
  // every high cycle is one message, so a stretched pulse shows as a double count
  always @(posedge i_ref_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_n_fatal <= 8'h0;
      o_n_nonfatal <= 8'h0;
      o_n_corr <= 8'h0;
    end else begin
      o_n_fatal <= o_n_fatal + {7'h0, i_fatal};
      o_n_nonfatal <= o_n_nonfatal + {7'h0, i_nonfatal};
      o_n_corr <= o_n_corr + {7'h0, i_corr};
    end
  end
endmodule // dpdc_rc_model

// [verification/downstream_port_device_control_tb_top.sv]
// testbench for the downstream port device control register
`timescale 1ns/100ps
module downstream_port_device_control_tb_top;
  reg clk, rst, wr, rd;
  reg [11:0] addr;
  reg [1:0] be;
  reg [15:0] wd;
  reg [7:0] cls;
  reg [3:0] ev, clr;
  wire [15:0] rdata;
  wire rv, hit, m_f, m_nf, m_c;
  wire [2:0] rq_code, pl_code;
  wire [12:0] fetch, pl_bytes;
  wire [3:0] det;
  wire [7:0] n_f, n_nf, n_c;
  integer n_fail, n_tests;
  dpdc_device_control dpdc_device_control_inst (.i_ref_clk(clk), .i_sys_rst(rst),
    .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr), .i_cfg_be(be), .i_cfg_wdata(wd),
    .i_cache_line_size(cls), .i_ur_event(ev[3]), .i_fatal_event(ev[2]),
    .i_nonfatal_event(ev[1]), .i_corr_event(ev[0]), .i_status_clr(clr),
    .o_cfg_rdata(rdata), .o_cfg_rd_valid(rv), .o_cfg_hit(hit), .o_max_read_req_size(rq_code),
    .o_max_payload_size(pl_code), .o_read_fetch_bytes(fetch), .o_max_payload_bytes(pl_bytes),
    .o_msg_err_fatal(m_f), .o_msg_err_nonfatal(m_nf), .o_msg_err_corr(m_c), .o_err_detected(det));
  dpdc_rc_model dpdc_rc_model_inst (.i_ref_clk(clk), .i_sys_rst(rst), .i_fatal(m_f),
    .i_nonfatal(m_nf), .i_corr(m_c), .o_n_fatal(n_f), .o_n_nonfatal(n_nf), .o_n_corr(n_c));
  task end_sim;
    begin
      $display("tests %0d fails %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // one access; read results are left standing for the caller to sample
  task acc(input w, input [11:0] a, input [1:0] b, input [15:0] d);
    begin
      @(posedge clk);
      #5 {wr, rd, addr, be, wd} = {w, !w, a, b, d};
      @(posedge clk);
      #5 {wr, rd} = 2'h0;
    end
  endtask
  task t_reset;
    begin
      acc(1'h0, 12'h098, 2'h0, 16'h0);
      chk(rdata, 16'h2000);
      chk({15'h0, hit}, 16'h1);
      chk({3'h0, fetch}, 16'h0200);
      chk({3'h0, pl_bytes}, 16'h0080);
      $display("t_reset done");
    end
  endtask
  task t_write;
    begin
      acc(1'h1, 12'h098, 2'h3, 16'hffff);
      acc(1'h0, 12'h098, 2'h0, 16'h0);
      chk(rdata, 16'h70ef);
      chk({3'h0, pl_bytes}, 16'h0080);
      chk({3'h0, fetch}, 16'h0080);
      chk({13'h0, rq_code}, 16'h0007);
      acc(1'h1, 12'h098, 2'h3, 16'h50a0);
      acc(1'h1, 12'h09a, 2'h3, 16'h0);
      chk({15'h0, hit}, 16'h0);
      chk({3'h0, pl_bytes}, 16'h1000);
      chk({3'h0, fetch}, 16'h1000);
      chk({10'h0, rq_code, pl_code}, 16'h002d);
      acc(1'h1, 12'h098, 2'h1, 16'h0);
      acc(1'h0, 12'h098, 2'h0, 16'h0);
      chk(rdata, 16'h5000);
      cls = 8'h10;
      @(posedge clk);
      @(posedge clk);
      #5 chk({3'h0, fetch}, 16'h0040);
      cls = 8'h0;
      $display("t_write done");
    end
  endtask
  task t_err(input [3:0] en);
    integer i;
    begin
      acc(1'h1, 12'h098, 2'h1, {12'h0, en});
      for (i = 0; i < 4; i = i + 1) begin
        @(posedge clk);
        #5 ev = 4'h1 << i;
        @(posedge clk);
        #5 ev = 4'h0;
        chk({m_f, m_nf, m_c}, {i == 2 && en[2], (i == 1 && en[1]) || (i == 3 && en[3]),
          i == 0 && en[0]});
        chk({12'h0, det}, 16'h1 << i);
        clr = 4'hf;
        @(posedge clk);
        #5 clr = 4'h0;
      end
      $display("t_err done");
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = !clk;
  end
  initial begin
    {rst, wr, rd, addr, be, wd, cls, ev, clr} = {1'h1, 48'h0};
    n_fail = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    #5 rst = 1'b0;
    t_reset;
    t_write;
    t_err(4'h0);
    t_err(4'hf);
    t_err(4'h8);
    chk({n_f, n_nf}, 16'h0103);
    chk({8'h0, n_c}, 16'h0001);
    end_sim;
  end
  initial begin
    #50000;
    n_fail = n_fail + 1;
    end_sim;
  end
endmodule // downstream_port_device_control_tb_top
bind dpdc_device_control dpdc_props #(.SIZE_W(SIZE_W)) dpdc_props_inst (.i_ref_clk(i_ref_clk),
  .i_sys_rst(i_sys_rst), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr),
  .i_ur_event(i_ur_event), .i_fatal_event(i_fatal_event), .i_nonfatal_event(i_nonfatal_event),
  .i_corr_event(i_corr_event), .o_cfg_rdata(o_cfg_rdata), .o_cfg_rd_valid(o_cfg_rd_valid),
  .o_cfg_hit(o_cfg_hit), .o_max_payload_size(o_max_payload_size),
  .o_max_payload_bytes(o_max_payload_bytes), .o_msg_err_fatal(o_msg_err_fatal),
  .o_msg_err_nonfatal(o_msg_err_nonfatal), .o_msg_err_corr(o_msg_err_corr),
  .o_err_detected(o_err_detected));
